// *** design/cell_monitor_cfg.svh ***
// Purpose: Constants for the cell monitor conversion sequencer
// Assumes: 125 MHz clock, times given in microseconds
// Notes:   Timing figures are per oversampling mode
`ifndef CELL_MONITOR_CFG_SVH
`define CELL_MONITOR_CFG_SVH

`define CLK_MHZ            125
`define REF_STARTUP_US     3000

`define ADDR_W             8
`define REG_CONFIG         8'h00
`define REG_THRESH         8'h04
`define REG_COMMAND        8'h08
`define REG_STATUS         8'h0c
`define REG_FLAGS          8'h10
`define CELL_PAGE          2'b01
`define AUX_PAGE           3'b100

`define CFG_OPT_BIT        0
`define CFG_KEEP_REFERENCE_ON_BIT      1
`define THR_UV_LSB         0
`define THR_OV_LSB         16
`define CMD_KIND_BIT       15
`define CMD_MD_LSB         8
`define CMD_CH_LSB         0
`define CH_INVALID         3'h7
`define FLG_OV_LSB         12
`define STAT_MODE_LSB      8

`define CONFIG_RST         2'h0
`define UV_RST             16'h0000
`define OV_RST             16'hffff

`define NUM_CELLS          12
`define HALF_CELLS         6
`define NUM_AUX            6
`define AUX_CHAN_BASE      12
`define LAST_STEP          3'h5

// First measure, sixth measure, first calibration, sixth calibration, two-cell total
`define T1M_27K  57
`define T6M_27K  290
`define T1C_27K  432
`define T6C_27K  1113
`define T2C_27K  201
`define T1M_14K  86
`define T6M_14K  465
`define T1C_14K  606
`define T6C_14K  1288
`define T2C_14K  230
`define T1M_7K   144
`define T6M_7K   814
`define T1C_7K   1072
`define T6C_7K   2335
`define T2C_7K   405
`define T1M_3K   260
`define T6M_3K   1512
`define T1C_3K   1770
`define T6C_3K   3033
`define T2C_3K   501
`define T1M_2K   493
`define T6M_2K   2908
`define T1C_2K   3166
`define T6C_2K   4430
`define T2C_2K   754
`define T1M_26H  29817
`define T6M_26H  178850
`define T1C_26H  182599
`define T6C_26H  201317
`define T2C_26H  33568

`endif

// *** design/cell_monitor_pkg.sv ***
// Purpose: Types shared by the conversion sequencer
// Assumes: Nothing beyond the constant header
// Notes:   Timing fields are microsecond counts
package cell_monitor_pkg;

	typedef enum logic [2:0] {MODE_27K, MODE_14K, MODE_7K, MODE_3K, MODE_2K, MODE_26H} osr_mode_e;

	typedef enum logic [1:0] {ST_IDLE, ST_REF_WAIT, ST_MEASURE, ST_CALIBRATE} seq_state_e;

	typedef struct packed {
		logic       measure;
		logic       calibrate;
		logic [4:0] channel;
	} conv_sel_s;

	typedef struct packed {
		logic [17:0] meas_first;
		logic [17:0] meas_next;
		logic [17:0] cal_first;
		logic [17:0] cal_next;
		logic [17:0] cal_single;
	} timing_s;

endpackage

// *** design/cell_monitor_adc_sequencer.sv ***
// Purpose: Conversion sequencer with APB registers for a twelve-cell monitor
// Assumes: Two converters outside supply signed raw codes at the end of each measure step
// Notes:   Zero-wait APB slave; commands are refused while a conversion runs
`timescale 1ns/10ps
`include "cell_monitor_cfg.svh"

module cell_monitor_adc_sequencer #(
	parameter logic [7:0] US_CYCLES = 8'(`CLK_MHZ)
) (
	input  wire logic                          clk,
	input  wire logic                          arst_n,
	input  wire logic [`ADDR_W-1:0]            paddr,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [31:0]                   pwdata,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	output cell_monitor_pkg::conv_sel_s        lower_sel,
	output cell_monitor_pkg::conv_sel_s        upper_sel,
	input  wire logic signed [16:0]            lower_raw,
	input  wire logic signed [16:0]            upper_raw,
	output logic                               reference_on,
	output logic                               busy
);
	import cell_monitor_pkg::*;

	function automatic timing_s mk_timing(input int t1m, input int t6m, input int t1c, input int t6c,
		input int t2c);
		timing_s t;
		t.meas_first = 18'(t1m);
		t.meas_next  = 18'((t6m - t1m) / 5);
		t.cal_first  = 18'(t1c - t6m);
		t.cal_next   = 18'((t6c - t1c) / 5);
		t.cal_single = 18'(t2c - t1m);
		return t;
	endfunction

	function automatic timing_s mode_timing(input osr_mode_e m);
		case (m)
			MODE_27K: return mk_timing(`T1M_27K, `T6M_27K, `T1C_27K, `T6C_27K, `T2C_27K);
			MODE_14K: return mk_timing(`T1M_14K, `T6M_14K, `T1C_14K, `T6C_14K, `T2C_14K);
			MODE_7K:  return mk_timing(`T1M_7K, `T6M_7K, `T1C_7K, `T6C_7K, `T2C_7K);
			MODE_3K:  return mk_timing(`T1M_3K, `T6M_3K, `T1C_3K, `T6C_3K, `T2C_3K);
			MODE_2K:  return mk_timing(`T1M_2K, `T6M_2K, `T1C_2K, `T6C_2K, `T2C_2K);
			MODE_26H: return mk_timing(`T1M_26H, `T6M_26H, `T1C_26H, `T6C_26H, `T2C_26H);
			default:  return mk_timing(`T1M_7K, `T6M_7K, `T1C_7K, `T6C_7K, `T2C_7K);
		endcase
	endfunction

	// Field value 00 has no mode of its own and falls back to MODE_7K, or to MODE_3K with the option bit set
	function automatic osr_mode_e decode_mode(input logic opt, input logic [1:0] md);
		case ({opt, md})
			3'b001:  return MODE_27K;
			3'b011:  return MODE_26H;
			3'b101:  return MODE_14K;
			3'b110:  return MODE_3K;
			3'b111:  return MODE_2K;
			3'b100:  return MODE_3K;
			default: return MODE_7K;
		endcase
	endfunction

	// A negative reading is held at zero, never wrapped
	function automatic logic [15:0] clamp(input logic signed [16:0] raw);
		return raw[16] ? 16'h0000 : raw[15:0];
	endfunction

	seq_state_e  state_q;
	seq_state_e  state_d;
	osr_mode_e   mode_q;
	logic        aux_q;
	logic [2:0]  chan_q;
	logic [2:0]  step_q;
	logic [7:0]  presc_q;
	logic [17:0] us_q;
	logic        ref_up_q;
	logic        pend_q;
	logic [1:0]  config_q;
	logic [15:0] uv_thr_q;
	logic [15:0] ov_thr_q;
	logic [31:0] prdata_q;
	logic [`NUM_CELLS-1:0] uv_flag_q;
	logic [`NUM_CELLS-1:0] ov_flag_q;
	logic [15:0] cell_res_q [`NUM_CELLS];
	logic [15:0] aux_res_q [`NUM_AUX];

	// Bus decode
	wire        access     = psel & penable;
	wire        setup      = psel & ~penable;
	wire        aligned    = paddr[1:0] == 2'b00;
	wire        hit_cfg    = aligned & (paddr == `REG_CONFIG);
	wire        hit_thr    = aligned & (paddr == `REG_THRESH);
	wire        hit_cmd    = aligned & (paddr == `REG_COMMAND);
	wire        hit_stat   = aligned & (paddr == `REG_STATUS);
	wire        hit_flag   = aligned & (paddr == `REG_FLAGS);
	wire [3:0]  cell_rd    = paddr[5:2];
	wire [2:0]  aux_rd     = paddr[4:2];
	wire        hit_cell   = aligned & (paddr[7:6] == `CELL_PAGE) & (cell_rd < 4'(`NUM_CELLS));
	wire        hit_aux    = aligned & (paddr[7:5] == `AUX_PAGE) & (aux_rd < 3'(`NUM_AUX));
	wire        mapped     = hit_cfg | hit_thr | hit_cmd | hit_stat | hit_flag | hit_cell | hit_aux;
	wire        wr         = access & pwrite & mapped;
	wire        keep_reference_on = config_q[`CFG_KEEP_REFERENCE_ON_BIT];
	wire        mode_option_bit   = config_q[`CFG_OPT_BIT];

	// Command fields
	wire        convert_aux_cmd     = pwdata[`CMD_KIND_BIT];
	wire [1:0]  oversampling_select = pwdata[`CMD_MD_LSB +: 2];
	wire [2:0]  cmd_chan            = pwdata[`CMD_CH_LSB +: 3];
	wire        cmd_room  = (state_q == ST_IDLE) | ((state_q == ST_REF_WAIT) & ~pend_q);
	wire        cmd_go    = wr & hit_cmd & cmd_room & (cmd_chan != `CH_INVALID);

	// Step timing
	timing_s    tm;
	assign tm = mode_timing(mode_q);
	wire        single    = chan_q != 3'h0;
	wire [2:0]  last_step = single ? 3'h0 : `LAST_STEP;
	wire        at_last   = step_q == last_step;
	wire [17:0] meas_len  = (step_q == 3'h0) ? tm.meas_first : tm.meas_next;
	wire [17:0] cal_len   = single ? tm.cal_single : ((step_q == 3'h0) ? tm.cal_first : tm.cal_next);
	wire [17:0] step_len  = (state_q == ST_REF_WAIT) ? 18'(`REF_STARTUP_US) :
		(state_q == ST_CALIBRATE) ? cal_len : meas_len;
	wire        us_tick   = presc_q == (US_CYCLES - 8'h01);
	wire        step_done = (state_q != ST_IDLE) & us_tick & (us_q == (step_len - 18'h1));
	wire        meas_end  = (state_q == ST_MEASURE) & step_done;

	// Channel of the current step; one formula serves pairs, single inputs and full sweeps
	wire [2:0]  idx       = single ? (chan_q - 3'h1) : step_q;
	wire [3:0]  up_idx    = 4'(idx) + 4'(`HALF_CELLS);
	wire [15:0] lower_code = clamp(lower_raw);
	wire [15:0] upper_code = clamp(upper_raw);

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (cmd_go) begin
					state_d = ref_up_q ? ST_MEASURE : ST_REF_WAIT;
				end else if (keep_reference_on & ~ref_up_q) begin
					state_d = ST_REF_WAIT;
				end
			end
			ST_REF_WAIT: begin
				if (step_done) begin
					state_d = (pend_q | cmd_go) ? ST_MEASURE : ST_IDLE;
				end
			end
			ST_MEASURE: begin
				if (step_done & at_last) begin
					state_d = ST_CALIBRATE;
				end
			end
			ST_CALIBRATE: begin
				if (step_done & at_last) begin
					state_d = ST_IDLE;
				end
			end
			default: state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Microsecond prescaler and step timer restart whenever the state changes
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			presc_q <= 8'h00;
			us_q    <= 18'h0;
		end else if ((state_d != state_q) | (state_q == ST_IDLE)) begin
			presc_q <= 8'h00;
			us_q    <= 18'h0;
		end else begin
			presc_q <= us_tick ? 8'h00 : presc_q + 8'h01;
			us_q    <= step_done ? 18'h0 : (us_tick ? us_q + 18'h1 : us_q);
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			step_q <= 3'h0;
		end else if (state_d != state_q) begin
			step_q <= 3'h0;
		end else if (step_done & ~at_last) begin
			step_q <= step_q + 3'h1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_q <= MODE_7K;
			aux_q  <= 1'b0;
			chan_q <= 3'h0;
			pend_q <= 1'b0;
		end else if (cmd_go) begin
			mode_q <= decode_mode(mode_option_bit, oversampling_select);
			aux_q  <= convert_aux_cmd;
			chan_q <= cmd_chan;
			pend_q <= 1'b1;
		end else if (state_d == ST_MEASURE) begin
			pend_q <= 1'b0;
		end
	end

	// Reference stays up between conversions only while the keep bit is set
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ref_up_q <= 1'b0;
		end else if ((state_q == ST_REF_WAIT) & step_done) begin
			ref_up_q <= 1'b1;
		end else if (~keep_reference_on & (state_d == ST_IDLE)) begin
			ref_up_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			config_q <= `CONFIG_RST;
			uv_thr_q <= `UV_RST;
			ov_thr_q <= `OV_RST;
		end else if (wr & hit_cfg) begin
			config_q <= pwdata[1:0];
		end else if (wr & hit_thr) begin
			uv_thr_q <= pwdata[`THR_UV_LSB +: 16];
			ov_thr_q <= pwdata[`THR_OV_LSB +: 16];
		end
	end

	// Each cell slot takes its code and refreshes both its flags when its pair is measured
	for (genvar g = 0; g < `NUM_CELLS; g++) begin : g_cell
		wire        mine = meas_end & ~aux_q & ((4'(g) == 4'(idx)) | (4'(g) == up_idx));
		wire [15:0] code = (g < `HALF_CELLS) ? lower_code : upper_code;
		always_ff @(posedge clk or negedge arst_n) begin
			if (!arst_n) begin
				cell_res_q[g] <= 16'h0000;
				uv_flag_q[g]  <= 1'b0;
				ov_flag_q[g]  <= 1'b0;
			end else if (mine) begin
				cell_res_q[g] <= code;
				uv_flag_q[g]  <= code < uv_thr_q;
				ov_flag_q[g]  <= code > ov_thr_q;
			end
		end
	end

	for (genvar a = 0; a < `NUM_AUX; a++) begin : g_aux
		always_ff @(posedge clk or negedge arst_n) begin
			if (!arst_n) begin
				aux_res_q[a] <= 16'h0000;
			end else if (meas_end & aux_q & (3'(a) == idx)) begin
				aux_res_q[a] <= lower_code;
			end
		end
	end

	// Read data is latched in the setup cycle so the access phase sees a flop output
	wire [31:0] status_word = {21'h0, 3'(mode_q), 4'h0, state_q == ST_CALIBRATE, state_q == ST_MEASURE,
		ref_up_q, busy};
	wire [31:0] rd_word = hit_cfg  ? {30'h0, config_q} :
		hit_thr  ? {ov_thr_q, uv_thr_q} :
		hit_stat ? status_word :
		hit_flag ? {8'h0, ov_flag_q, uv_flag_q} :
		hit_cell ? {16'h0, cell_res_q[cell_rd]} :
		hit_aux  ? {16'h0, aux_res_q[aux_rd]} : 32'h0;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			prdata_q <= 32'h0;
		end else if (setup) begin
			prdata_q <= pwrite ? 32'h0 : rd_word;
		end
	end

	assign prdata       = prdata_q;
	assign pready       = 1'b1;
	assign pslverr      = access & ~mapped;
	assign busy         = pend_q | (state_q == ST_MEASURE) | (state_q == ST_CALIBRATE);
	assign reference_on = ref_up_q | (state_q != ST_IDLE);

	assign lower_sel.measure   = state_q == ST_MEASURE;
	assign lower_sel.calibrate = state_q == ST_CALIBRATE;
	assign lower_sel.channel   = aux_q ? 5'(idx) + 5'(`AUX_CHAN_BASE) : 5'(idx);
	assign upper_sel.measure   = (state_q == ST_MEASURE) & ~aux_q;
	assign upper_sel.calibrate = (state_q == ST_CALIBRATE) & ~aux_q;
	assign upper_sel.channel   = 5'(up_idx);

endmodule

// *** testbench/seq_checker_asserts.sv ***
// Purpose: Port checks for the conversion sequencer
// Assumes: US_CYCLES matches the bound instance
// Notes:   Step length is held to the fastest mode only
`timescale 1ns/10ps
module seq_checker
	import cell_monitor_pkg::*;
#(
	parameter logic [7:0] US_CYCLES = 8'd125
) (
	input wire logic        clk,
	input wire logic        arst_n,
	input wire logic [7:0]  paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire conv_sel_s   lower_sel,
	input wire conv_sel_s   upper_sel,
	input wire logic        reference_on,
	input wire logic        busy
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	localparam int T1M_MIN = 57 * US_CYCLES;
	logic [19:0] meas_cnt_q;
	wire         cmd_wr = psel && penable && pwrite && paddr == 8'h08;
	// Saturates so a filtered-mode run cannot wrap
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			meas_cnt_q <= '0;
		else if (!lower_sel.measure)
			meas_cnt_q <= '0;
		else if (meas_cnt_q != '1)
			meas_cnt_q <= meas_cnt_q + 1'b1;
	end
	property p_busy_start;
		cmd_wr && !busy && pwdata[2:0] != 3'h7 |=> busy;
	endproperty
	a_busy_start: assert property (p_busy_start) else $error("command not taken");
	property p_ref_wait;
		$rose(busy) && !$past(reference_on) |-> (!lower_sel.measure)[*8];
	endproperty
	a_ref_wait: assert property (p_ref_wait) else $error("measured before reference up");
	property p_pair;
		lower_sel.measure && upper_sel.measure |-> upper_sel.channel == lower_sel.channel + 5'd6;
	endproperty
	a_pair: assert property (p_pair) else $error("converter channels not paired");
	property p_aux_lower;
		lower_sel.measure && lower_sel.channel >= 5'd12 |-> !upper_sel.measure && !upper_sel.calibrate;
	endproperty
	a_aux_lower: assert property (p_aux_lower) else $error("upper converter used for aux");
	property p_done_after_cal;
		$fell(busy) |-> $past(lower_sel.calibrate);
	endproperty
	a_done_after_cal: assert property (p_done_after_cal) else $error("done without calibration");
	property p_cal_alone;
		lower_sel.calibrate |-> !lower_sel.measure && busy;
	endproperty
	a_cal_alone: assert property (p_cal_alone) else $error("calibrate overlaps measure");
	property p_active;
		lower_sel.measure || lower_sel.calibrate |-> busy && reference_on;
	endproperty
	a_active: assert property (p_active) else $error("activity while idle");
	property p_first_meas;
		$fell(lower_sel.measure) |-> meas_cnt_q >= T1M_MIN - 2;
	endproperty
	a_first_meas: assert property (p_first_meas) else $error("measure phase too short");
endmodule

bind cell_monitor_adc_sequencer seq_checker #(.US_CYCLES(US_CYCLES)) seq_checker_i (.clk(clk), .arst_n(arst_n),
	.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .lower_sel(lower_sel),
	.upper_sel(upper_sel), .reference_on(reference_on), .busy(busy));

// *** testbench/conv_model.sv ***
// Purpose: Converter stand-in giving a raw code per channel
// Assumes: Code is base plus 37 per channel index
// Notes:   Shows the inverse level outside measure so stale codes are caught
`timescale 1ns/10ps
module conv_model
	import cell_monitor_pkg::*;
(
	input wire conv_sel_s          sel,
	input wire logic signed [16:0] base,
	output logic signed [16:0]     raw
);
	wire signed [16:0] level = base + $signed({12'h0, sel.channel}) * 17'sd37;
	assign raw = sel.measure ? level : ~level;
endmodule

// *** testbench/cell_monitor_adc_sequencer_bench.sv ***
// Purpose: Self-checking bench for the conversion sequencer
// Assumes: US_CYCLES of 1, so one microsecond is one clock
// Notes:   Filtered all-cells run is skipped for run length
`timescale 1ns/10ps
`include "cell_monitor_cfg.svh"
module cell_monitor_adc_sequencer_bench;
	import cell_monitor_pkg::*;
	logic clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, bprev = 0;
	logic [7:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, fl;
	logic pready, pslverr, reference_on, busy;
	conv_sel_s lower_sel, upper_sel;
	logic signed [16:0] base = '0, lower_raw, upper_raw;
	int n_errors = 0, n_checks = 0, cyc = 0, t0 = 0, b, uv, ov;
	logic [31:0] rd_q[$];
	int dur_q[$];
	int t2c[6] = '{`T2C_27K, `T2C_14K, `T2C_7K, `T2C_3K, `T2C_2K, `T2C_26H};
	logic [2:0] om[6] = '{3'b001, 3'b101, 3'b010, 3'b110, 3'b111, 3'b011};
	always #4 clk = ~clk;
	cell_monitor_adc_sequencer #(.US_CYCLES(8'd1)) cell_monitor_adc_sequencer_i (.clk(clk), .arst_n(arst_n),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .lower_sel(lower_sel), .upper_sel(upper_sel),
		.lower_raw(lower_raw), .upper_raw(upper_raw), .reference_on(reference_on), .busy(busy));
	conv_model conv_model_i (.sel(lower_sel), .base(base), .raw(lower_raw));
	conv_model conv_model_hi_i (.sel(upper_sel), .base(base), .raw(upper_raw));
	function automatic logic [15:0] code(input int bb, input int ch);
		int r;
		r = bb + ch * 37;
		return (r < 0) ? 16'h0 : 16'(r);
	endfunction
	task automatic test_done;
		$display("Checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic cmp_dur(input int g, input int e);
		n_checks++;
		if (g < e - 8 || g > e + 8) begin
			n_errors++;
			$display("BAD %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		psel <= 1'b0; penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rd_q.push_back(e);
		apb(a, 1'b0, 32'h0);
	endtask
	// Host waits out the whole conversion before reading results
	task automatic cmd(input logic k, input logic [1:0] md, input logic [2:0] ch, input int dur);
		if (dur > 0) dur_q.push_back(dur);
		apb(8'h08, 1'b1, {16'h0, k, 5'h0, md, 5'h0, ch});
		@(posedge clk);
		while (busy === 1'b1) @(posedge clk);
	endtask
	// Results and conversion lengths are judged here as they appear
	always @(posedge clk) begin
		cyc++;
		if (psel && penable && pready && !pwrite && rd_q.size() > 0) cmp_word(prdata, rd_q.pop_front());
		// Only the hole at 0x3c is ever addressed off the map, so it alone must raise the error
		if (psel && penable && pready) cmp_word({31'h0, pslverr}, {31'h0, paddr == 8'h3c});
		if (busy === 1'b1 && !bprev) t0 = cyc;
		if (busy === 1'b0 && bprev && dur_q.size() > 0) cmp_dur(cyc - t0, dur_q.pop_front());
		bprev = (busy === 1'b1);
		if (cyc == 60000) begin
			n_errors++;
			test_done;
		end
	end
	initial begin
		void'($urandom(70));
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		rd(8'h00, 32'h0);
		rd(8'h04, 32'hffff0000);
		rd(8'h0c, 32'h200);
		rd(8'h3c, 32'h0);
		$display("Reset values done");
		b = $urandom_range(30000, 100);
		base <= 17'(b);
		uv = b + 111;
		ov = b + 296;
		apb(8'h04, 1'b1, {16'(ov), 16'(uv)});
		cmd(1'b0, 2'b01, 3'h0, `REF_STARTUP_US + `T6C_27K);
		fl = '0;
		for (int i = 0; i < 12; i++) begin
			rd(8'h40 + 8'(4 * i), {16'h0, code(b, i)});
			fl[i] = code(b, i) < uv;
			fl[12 + i] = code(b, i) > ov;
		end
		rd(8'h10, fl);
		$display("All cells done");
		for (int m = 0; m < 6; m++) begin
			apb(8'h00, 1'b1, {30'h0, 1'b1, om[m][2]});
			if (m == 0) repeat (`REF_STARTUP_US + 100) @(posedge clk);
			b = $urandom_range(60000, 0);
			base <= 17'(b);
			cmd(1'b0, om[m][1:0], 3'(m + 1), t2c[m]);
			rd(8'h40 + 8'(4 * m), {16'h0, code(b, m)});
			rd(8'h40 + 8'(4 * m + 24), {16'h0, code(b, m + 6)});
		end
		apb(8'h00, 1'b1, 32'h2);
		cmd(1'b0, 2'b00, 3'h1, `T2C_7K);
		rd(8'h0c, 32'h202);
		$display("Modes done");
		base <= -17'sd500;
		cmd(1'b1, 2'b01, 3'h0, `T6C_27K);
		for (int j = 0; j < 6; j++) rd(8'h80 + 8'(4 * j), {16'h0, code(-500, j + 12)});
		cmd(1'b1, 2'b01, 3'h7, 0);
		cmp_word({31'h0, busy}, 32'h0);
		$display("Aux done");
		repeat (2) @(posedge clk);
		test_done;
	end
endmodule
